/* inc/cts_pkg.sv */
// Shared constants and types for the 16-bit counter/timer
package cts_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_TCR   = 8'h04;
    localparam logic [7:0] OFS_TC    = 8'h08;
    localparam logic [7:0] OFS_PR    = 8'h0C;
    localparam logic [7:0] OFS_PC    = 8'h10;
    localparam logic [7:0] OFS_MCR   = 8'h14;
    localparam logic [7:0] OFS_MR0   = 8'h18;
    localparam logic [7:0] OFS_MR1   = 8'h1C;
    localparam logic [7:0] OFS_MR2   = 8'h20;
    localparam logic [7:0] OFS_MR3   = 8'h24;
    localparam logic [7:0] OFS_CCR   = 8'h28;
    localparam logic [7:0] OFS_CAP   = 8'h2C;
    localparam logic [7:0] OFS_EMR   = 8'h3C;
    localparam logic [7:0] OFS_COUNT_SOURCE_CONTROL  = 8'h70;
    localparam logic [7:0] OFS_PWMC  = 8'h74;
    // Field positions
    localparam int TCR_EN_POS  = 0;   // count_enable_bit
    localparam int TCR_RST_POS = 1;   // count_reset_bit
    localparam int MCR_IRQ_POS = 0;   // Per-channel interrupt enable
    localparam int MCR_RST_POS = 1;   // Per-channel reset on match
    localparam int MCR_STP_POS = 2;   // Per-channel halt on match
    localparam int MCR_STRIDE  = 3;   // Bits per match channel
    localparam int CCR_RISE_POS = 0;  // Capture on rising edge
    localparam int CCR_FALL_POS = 1;  // Capture on falling edge
    localparam int CCR_IRQ_POS  = 2;  // Flag on capture
    localparam int FLAG_CAP_POS = 4;  // Capture flag bit
    localparam int EMR_CTL_POS  = 4;  // First action field in EXTERNAL_MATCH_CONTROL
    // Reset values
    localparam logic [15:0] RST_CNT   = 16'h0000;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    // Clock
    localparam int CLK_PERIOD_NS = 10;
    // Count source modes
    typedef enum logic [1:0] {
        CTS_MODE_TIMER = 2'b00,
        CTS_MODE_RISE  = 2'b01,
        CTS_MODE_FALL  = 2'b10,
        CTS_MODE_BOTH  = 2'b11
    } cts_mode_e;
    // External match actions
    typedef enum logic [1:0] {
        CTS_EMC_HOLD   = 2'b00,
        CTS_EMC_LOW    = 2'b01,
        CTS_EMC_HIGH   = 2'b10,
        CTS_EMC_TOGGLE = 2'b11
    } cts_emc_e;
    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } cts_bus_req_s;
endpackage

/* hdl/cts_edge_sync.sv */
// Pin synchroniser with registered edge pulses
`timescale 1ns/1ns
module cts_edge_sync (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      rise_ff,
    output logic      fall_ff
);
    logic s1_ff, s2_ff, s3_ff;          // Two sync stages plus history
    logic nxt_rise, nxt_fall;

    // Edge decode reads only settled stages
    always_comb begin
        nxt_rise = s2_ff & ~s3_ff;
        nxt_fall = ~s2_ff & s3_ff;
    end

    // Register stages and pulses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            s1_ff   <= async_in;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
        end
    end
endmodule

/* hdl/cts_ext_match.sv */
// One external match channel: state bit, action and PWM pin
`timescale 1ns/1ns
module cts_ext_match
    import cts_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic             wr_bit,
    input  wire logic             hit,
    input  wire cts_pkg::cts_emc_e ctrl,
    input  wire logic             pwm_en,
    input  wire logic             pwm_level,
    output logic                  state_ff,
    output logic                  pin_ff
);
    logic nxt_state, nxt_pin;

    // Match action beats a software write
    always_comb begin
        nxt_state = state_ff;
        if (hit) begin
            case (ctrl)
                CTS_EMC_HOLD:   nxt_state = state_ff;
                CTS_EMC_LOW:    nxt_state = 1'b0;
                CTS_EMC_HIGH:   nxt_state = 1'b1;
                CTS_EMC_TOGGLE: nxt_state = ~state_ff;
                default:        nxt_state = state_ff;
            endcase
        end else if (wr_en) begin
            nxt_state = wr_bit;
        end
        nxt_pin = pwm_en ? pwm_level : nxt_state;  // RL9
    end

    // Register state and pin
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= 1'b0;
            pin_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pin_ff   <= nxt_pin;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_pwm_pin;
        pwm_en |=> pin_ff == $past(pwm_level);
    endproperty
    a_pwm_pin: assert property (p_pwm_pin) else $error("pwm pin wrong"); // RL9

    property p_toggle;
        hit && ctrl == CTS_EMC_TOGGLE && !pwm_en |=> pin_ff != $past(state_ff);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle failed"); // RL19
endmodule

/* hdl/cts_timer.sv */
// 16-bit counter/timer top with register bank
// Notes on behaviour
// RL1: count advances every divider_limit+1 enabled steps
// RL2: at limit, next clock increments count, zeroes divider
// RL3: divider tick count readable and writable
// RL4: four match values: reset, halt, flag
// RL5: capture control picks edges and flag
// RL6: qualifying capture edge copies count
// RL7: external match control drives two pins
// RL8: count source selects timer or edge counting
// RL9: PWM enable switches pin to PWM
// RL10: five sticky pending flags
// RL11: match flags bits 0-3, capture bit 4
// RL12: write one clears flag, zero keeps
// RL13: control bit 0 enables both counters
// RL14: control bit 1 holds both counters zero
// RL15: software keeps control bits 31:2 zero
// RL16: all used bits reset to zero
// RL17: count wraps at maximum, no flag
// RL18: halt match stops counters, clears enable
// RL19: match drives pin toggle/low/high/hold
// RL20: full equality test every clock
`timescale 1ns/1ns
module cts_timer
    import cts_pkg::*;
#(
    parameter int CNT_W = 16          // Counter width
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire cts_pkg::cts_bus_req_s bus_req,
    output logic [31:0]               rd_data_ff,
    input  wire logic                 capture_input,
    output logic [1:0]                match_outputs
);
    // Collect one control bit of every match channel
    function automatic logic [3:0] mcr_sel(input logic [11:0] match_control, input int pos);
        logic [3:0] r;
        for (int n = 0; n < 4; n++) begin
            r[n] = match_control[n*MCR_STRIDE+pos];
        end
        return r;
    endfunction

    // Register state
    logic [4:0]       flags_ff;       // Pending flags
    logic             en_ff;          // count_enable_bit
    logic             count_reset_bit_ff;        // count_reset_bit
    logic [CNT_W-1:0] tc_ff;          // timer_count
    logic [CNT_W-1:0] pr_ff;          // divider_limit
    logic [CNT_W-1:0] pc_ff;          // divider_tick_count
    logic [11:0]      mcr_ff;         // match_control
    logic [CNT_W-1:0] mr_ff [4];      // match_value_0..3
    logic [2:0]       ccr_ff;         // capture_control
    logic [CNT_W-1:0] cap_ff;         // capture_value_0
    logic [7:0]       emc_ff;         // Match action fields
    logic [3:0]       count_source_control_ff;        // count_source_control
    logic [1:0]       pwm_ff;         // pwm_enable_control
    // Next values
    logic [4:0]       nxt_flags;
    logic             nxt_en, nxt_count_reset_bit;
    logic [CNT_W-1:0] nxt_tc, nxt_pr, nxt_pc, nxt_cap;
    logic [11:0]      nxt_mcr;
    logic [CNT_W-1:0] nxt_mr [4];
    logic [2:0]       nxt_ccr;
    logic [7:0]       nxt_emc;
    logic [3:0]       nxt_count_source_control;
    logic [1:0]       nxt_pwm;
    logic [31:0]      nxt_rd;
    // Datapath
    logic             cap_rise, cap_fall;  // Synchronised edges
    logic             src_evt;        // Counting event this cycle
    logic             step;           // Divider may move
    logic             at_limit;       // Divider at its limit
    logic             adv;            // Count advances
    logic [3:0]       eq;             // Match equality per channel
    logic [3:0]       hit;            // Match event per channel
    logic             cap_evt;        // Qualifying capture
    logic [4:0]       set_flags;
    logic [3:0]       em_state;       // External match state bits
    logic [3:0]       em_pin;         // External match pin levels
    logic [31:0]      rd_val;
    logic             wr_tcr, wr_tc, wr_pc, wr_flags;
    cts_mode_e        mode;

    // Capture pin synchroniser
    cts_edge_sync u_cap_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .async_in(capture_input),
        .rise_ff (cap_rise),
        .fall_ff (cap_fall)
    );

    // Write strobes per register
    always_comb begin
        wr_tcr   = bus_req.wr && bus_req.addr == OFS_TCR;
        wr_tc    = bus_req.wr && bus_req.addr == OFS_TC;
        wr_pc    = bus_req.wr && bus_req.addr == OFS_PC;
        wr_flags = bus_req.wr && bus_req.addr == OFS_FLAGS;
    end

    // Count source and match detection
    always_comb begin
        mode = cts_mode_e'(count_source_control_ff[1:0]);
        case (mode) // RL8
            CTS_MODE_TIMER: src_evt = 1'b1;
            CTS_MODE_RISE:  src_evt = cap_rise;
            CTS_MODE_FALL:  src_evt = cap_fall;
            CTS_MODE_BOTH:  src_evt = cap_rise | cap_fall;
            default:        src_evt = 1'b0;
        endcase
        step     = en_ff && !count_reset_bit_ff && src_evt; // RL13
        at_limit = pc_ff == pr_ff;
        adv      = step && at_limit;
        for (int n = 0; n < 4; n++) begin
            eq[n] = tc_ff == mr_ff[n]; // RL20
        end
        hit     = eq & {4{adv}}; // RL4
        cap_evt = (cap_rise & ccr_ff[CCR_RISE_POS]) | (cap_fall & ccr_ff[CCR_FALL_POS]); // RL5
        set_flags = {cap_evt & ccr_ff[CCR_IRQ_POS], hit & mcr_sel(mcr_ff, MCR_IRQ_POS)}; // RL11
    end

    // Counter, control and flag next state
    always_comb begin
        nxt_tc   = tc_ff;
        nxt_pc   = pc_ff;
        nxt_en   = en_ff;
        nxt_count_reset_bit = count_reset_bit_ff;
        if (wr_tcr) begin
            nxt_en   = bus_req.wdata[TCR_EN_POS];
            nxt_count_reset_bit = bus_req.wdata[TCR_RST_POS];
        end
        if (step) begin
            if (at_limit) begin
                nxt_pc = RST_CNT; // RL2
                nxt_tc = tc_ff + 16'h0001; // RL1 RL17
            end else begin
                nxt_pc = pc_ff + 16'h0001;
            end
        end
        if (|(hit & mcr_sel(mcr_ff, MCR_RST_POS))) begin
            nxt_tc = RST_CNT;
        end
        if (|(hit & mcr_sel(mcr_ff, MCR_STP_POS))) begin
            nxt_tc = tc_ff; // RL18
            nxt_pc = RST_CNT;
            nxt_en = 1'b0;
        end
        if (wr_tc) begin
            nxt_tc = bus_req.wdata[CNT_W-1:0];
        end
        if (wr_pc) begin
            nxt_pc = bus_req.wdata[CNT_W-1:0]; // RL3
        end
        if (count_reset_bit_ff || (wr_tcr && bus_req.wdata[TCR_RST_POS])) begin
            nxt_tc = RST_CNT; // RL14
            nxt_pc = RST_CNT;
        end
        // Set beats a same-cycle clear
        nxt_flags = flags_ff & ~({5{wr_flags}} & bus_req.wdata[4:0]); // RL12
        nxt_flags = nxt_flags | set_flags; // RL10
        nxt_cap   = cap_evt ? tc_ff : cap_ff; // RL6
    end

    // Configuration registers written by software
    always_comb begin
        nxt_pr   = pr_ff;
        nxt_mcr  = mcr_ff;
        nxt_mr   = mr_ff;
        nxt_ccr  = ccr_ff;
        nxt_emc  = emc_ff;
        nxt_count_source_control = count_source_control_ff;
        nxt_pwm  = pwm_ff;
        if (bus_req.wr) begin
            case (bus_req.addr)
                OFS_PR:   nxt_pr = bus_req.wdata[CNT_W-1:0];
                OFS_MCR:  nxt_mcr = bus_req.wdata[11:0];
                OFS_MR0:  nxt_mr[0] = bus_req.wdata[CNT_W-1:0];
                OFS_MR1:  nxt_mr[1] = bus_req.wdata[CNT_W-1:0];
                OFS_MR2:  nxt_mr[2] = bus_req.wdata[CNT_W-1:0];
                OFS_MR3:  nxt_mr[3] = bus_req.wdata[CNT_W-1:0];
                OFS_CCR:  nxt_ccr = bus_req.wdata[2:0];
                OFS_EMR:  nxt_emc = bus_req.wdata[EMR_CTL_POS+7:EMR_CTL_POS];
                OFS_COUNT_SOURCE_CONTROL: nxt_count_source_control = bus_req.wdata[3:0];
                OFS_PWMC: nxt_pwm = bus_req.wdata[1:0];
                default:  nxt_pr = pr_ff;
            endcase
        end
    end

    // External match channels, two reach pins
    for (genvar n = 0; n < 4; n++) begin : g_em
        cts_ext_match u_em (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .wr_en    (bus_req.wr && bus_req.addr == OFS_EMR),
            .wr_bit   (bus_req.wdata[n]),
            .hit      (hit[n]),
            .ctrl     (cts_emc_e'(emc_ff[2*n+1:2*n])),
            .pwm_en   ((n < 2) ? pwm_ff[n%2] : 1'b0),
            .pwm_level(tc_ff >= mr_ff[n]),
            .state_ff (em_state[n]),
            .pin_ff   (em_pin[n])
        ); // RL7 RL19
    end
    assign match_outputs = em_pin[1:0];

    // Read data mux, unmapped reads zero
    always_comb begin
        rd_val = RST_WORD;
        case (bus_req.addr)
            OFS_FLAGS: rd_val[4:0] = flags_ff;
            OFS_TCR:   rd_val[1:0] = {count_reset_bit_ff, en_ff};
            OFS_TC:    rd_val[CNT_W-1:0] = tc_ff;
            OFS_PR:    rd_val[CNT_W-1:0] = pr_ff;
            OFS_PC:    rd_val[CNT_W-1:0] = pc_ff; // RL3
            OFS_MCR:   rd_val[11:0] = mcr_ff;
            OFS_MR0:   rd_val[CNT_W-1:0] = mr_ff[0];
            OFS_MR1:   rd_val[CNT_W-1:0] = mr_ff[1];
            OFS_MR2:   rd_val[CNT_W-1:0] = mr_ff[2];
            OFS_MR3:   rd_val[CNT_W-1:0] = mr_ff[3];
            OFS_CCR:   rd_val[2:0] = ccr_ff;
            OFS_CAP:   rd_val[CNT_W-1:0] = cap_ff;
            OFS_EMR:   rd_val[11:0] = {emc_ff, em_state};
            OFS_COUNT_SOURCE_CONTROL:  rd_val[3:0] = count_source_control_ff;
            OFS_PWMC:  rd_val[1:0] = pwm_ff;
            default:   rd_val = RST_WORD;
        endcase
        nxt_rd = bus_req.rd ? rd_val : RST_WORD;
    end

    // Register everything; reset clears all used bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff   <= 5'h00; // RL16
            en_ff      <= 1'b0;
            count_reset_bit_ff    <= 1'b0;
            tc_ff      <= RST_CNT;
            pr_ff      <= RST_CNT;
            pc_ff      <= RST_CNT;
            mcr_ff     <= 12'h000;
            for (int n = 0; n < 4; n++) begin
                mr_ff[n] <= RST_CNT;
            end
            ccr_ff     <= 3'h0;
            cap_ff     <= RST_CNT;
            emc_ff     <= 8'h00;
            count_source_control_ff    <= 4'h0;
            pwm_ff     <= 2'h0;
            rd_data_ff <= RST_WORD;
        end else begin
            flags_ff   <= nxt_flags;
            en_ff      <= nxt_en;
            count_reset_bit_ff    <= nxt_count_reset_bit;
            tc_ff      <= nxt_tc;
            pr_ff      <= nxt_pr;
            pc_ff      <= nxt_pc;
            mcr_ff     <= nxt_mcr;
            mr_ff      <= nxt_mr;
            ccr_ff     <= nxt_ccr;
            cap_ff     <= nxt_cap;
            emc_ff     <= nxt_emc;
            count_source_control_ff    <= nxt_count_source_control;
            pwm_ff     <= nxt_pwm;
            rd_data_ff <= nxt_rd;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_hold_reset;
        count_reset_bit_ff |-> tc_ff == RST_CNT && pc_ff == RST_CNT;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("counters not held"); // RL14

    property p_advance;
        adv && !count_reset_bit_ff && mcr_ff == 12'h000 && !wr_tc && !wr_pc && !wr_tcr
            |=> tc_ff == $past(tc_ff) + 16'h0001 && pc_ff == RST_CNT;
    endproperty
    a_advance: assert property (p_advance) else $error("advance wrong"); // RL2

    property p_divide;
        en_ff && mode == CTS_MODE_TIMER && !count_reset_bit_ff && pr_ff == 16'h0002 && pc_ff == RST_CNT
            && mcr_ff == 12'h000 && !bus_req.wr |=> !adv ##1 adv;
    endproperty
    a_divide: assert property (p_divide) else $error("divide ratio wrong"); // RL1

    property p_stopped;
        !en_ff && !wr_tc && !wr_pc && !wr_tcr |=> $stable(tc_ff) && $stable(pc_ff);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count while disabled"); // RL13

    property p_clear;
        wr_flags && set_flags == 5'h00 |=> (flags_ff & $past(bus_req.wdata[4:0])) == 5'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared"); // RL12

    property p_flag_set;
        hit[0] && mcr_ff[MCR_IRQ_POS] |=> flags_ff[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("match flag missing"); // RL10

    property p_halt;
        |(hit & mcr_sel(mcr_ff, MCR_STP_POS)) |=> !en_ff && $stable(tc_ff);
    endproperty
    a_halt: assert property (p_halt) else $error("halt failed"); // RL18

    property p_capture;
        cap_evt |=> cap_ff == $past(tc_ff);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong"); // RL6

    property p_wrap;
        adv && tc_ff == 16'hFFFF && set_flags == 5'h00 && !wr_flags && !bus_req.wr
            |=> tc_ff == RST_CNT && $stable(flags_ff);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap wrong"); // RL17

    property p_read_pc;
        bus_req.rd && bus_req.addr == OFS_PC |=> rd_data_ff == {16'h0000, $past(pc_ff)};
    endproperty
    a_read_pc: assert property (p_read_pc) else $error("divider read wrong"); // RL3

    // Software write of the divider lands unless control reset holds it
    property p_pc_write;
        wr_pc && !count_reset_bit_ff |=> pc_ff == $past(bus_req.wdata[CNT_W-1:0]);
    endproperty
    a_pc_write: assert property (p_pc_write) else $error("divider write lost"); // RL3

    // Capture with flag enabled sets the capture flag bit
    property p_cap_flag;
        cap_evt && ccr_ff[CCR_IRQ_POS] |=> flags_ff[FLAG_CAP_POS];
    endproperty
    a_cap_flag: assert property (p_cap_flag) else $error("capture flag missing"); // RL11

    c_match_reset: cover property (hit[0] && mcr_ff[MCR_RST_POS] ##1 tc_ff == RST_CNT);
    c_capture:     cover property (cap_evt && ccr_ff[CCR_IRQ_POS]);
    c_wrap:        cover property (adv && tc_ff == 16'hFFFF);
    c_halt:        cover property (|(hit & mcr_sel(mcr_ff, MCR_STP_POS)));
    c_pwm_high:    cover property (pwm_ff[0] && match_outputs[0]);
endmodule

/* test/cts_pin_model.sv */
// Far-side pin model: drives the capture pin and watches match pin 0
`timescale 1ns/1ns
module cts_pin_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       flip_req,
    input  wire logic [1:0] match_outputs,
    output logic            capture_input,
    output logic [7:0]      pin0_rises
);
    logic prev_ff; // Last seen level of match pin 0

    // Pin moves only on request, right after a clock edge, like a slow source
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_input <= 1'b0;
            prev_ff       <= 1'b0;
            pin0_rises    <= 8'h00;
        end else begin
            if (flip_req) begin
                capture_input <= ~capture_input;
            end
            prev_ff <= match_outputs[0];
            // Count low-to-high moves of match pin 0
            if (match_outputs[0] && !prev_ff) begin
                pin0_rises <= pin0_rises + 8'h01;
            end
        end
    end
endmodule

/* test/cts_timer_tb_top.sv */
// Register-level testbench for the 16-bit counter/timer
`timescale 1ns/1ns
module cts_timer_tb_top;
    import cts_pkg::*;
    logic                  ref_clk;       // Bench clock
    logic                  rst_n;         // Active-low reset
    cts_pkg::cts_bus_req_s bus_req;       // Register bus request
    logic [31:0]           rd_data_ff;    // Read data from the timer
    logic                  capture_input; // Capture pin
    logic [1:0]            match_outputs; // Match pins
    logic                  flip_req;      // Pin transition request
    logic [7:0]            pin0_rises;    // Match pin 0 rising count
    int                    errors;        // Mismatch count
    int                    checked;       // Comparison count

    cts_timer dut_u (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .bus_req       (bus_req),
        .rd_data_ff    (rd_data_ff),
        .capture_input (capture_input),
        .match_outputs (match_outputs)
    );

    cts_pin_model pin_u (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .flip_req      (flip_req),
        .match_outputs (match_outputs),
        .capture_input (capture_input),
        .pin0_rises    (pin0_rises)
    );

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // Compare and report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    // One-cycle write strobe, released at the sampling edge
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        d = rd_data_ff;
    endtask

    // Read and compare
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus_rd(a, d);
        chk(what, exp, d);
    endtask

    // One capture pin transition, then time for sync and edge detect
    task automatic pin_flip();
        @(posedge ref_clk);
        flip_req <= 1'b1;
        @(posedge ref_clk);
        flip_req <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    // Single exit point of the run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        logic [7:0] ofs [15];
        logic [7:0] rw16 [6];
        ofs = '{OFS_FLAGS, OFS_TCR, OFS_TC, OFS_PR, OFS_PC, OFS_MCR, OFS_MR0, OFS_MR1,
                OFS_MR2, OFS_MR3, OFS_CCR, OFS_CAP, OFS_EMR, OFS_COUNT_SOURCE_CONTROL, OFS_PWMC};
        rw16 = '{OFS_PR, OFS_PC, OFS_MR0, OFS_MR1, OFS_MR2, OFS_MR3};
        ref_clk  = 1'b0;
        rst_n    = 1'b0;
        bus_req  = '0;
        flip_req = 1'b0;
        errors   = 0;
        checked  = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;

        // Every register reads zero after reset, unmapped place too
        foreach (ofs[i]) rd_chk("reset value", ofs[i], RST_WORD);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        $display("test reset_values done");

        // Read/write of 16-bit registers, read-only capture, unmapped write
        foreach (rw16[i]) bus_wr(rw16[i], 32'h0000_ABC0 + i);
        foreach (rw16[i]) rd_chk("rw reg", rw16[i], 32'h0000_ABC0 + i);
        bus_wr(OFS_CAP, 32'h0000_FFFF);
        bus_wr(8'h40, 32'h0000_FFFF);
        rd_chk("capture ro", OFS_CAP, 32'h0000_0000);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
        foreach (rw16[i]) bus_wr(rw16[i], 32'h0000_0000);
        $display("test read_write done");

        // Divider limit 2, exactly ten counting steps
        bus_wr(OFS_PR, 32'h0000_0002);
        bus_wr(OFS_TCR, 32'h0000_0001);
        repeat (8) @(posedge ref_clk);
        bus_wr(OFS_TCR, 32'h0000_0000);
        rd_chk("timer_count", OFS_TC, 32'h0000_0003);
        rd_chk("divider_tick_count", OFS_PC, 32'h0000_0001);
        $display("test prescale done");

        // Control reset clears and holds both counters, beats a count write
        bus_wr(OFS_TCR, 32'h0000_0002);
        bus_wr(OFS_TC, 32'h0000_0009);
        rd_chk("timer_count", OFS_TC, 32'h0000_0000);
        rd_chk("divider_tick_count", OFS_PC, 32'h0000_0000);
        rd_chk("timer_control", OFS_TCR, 32'h0000_0002);
        bus_wr(OFS_TCR, 32'h0000_0000);
        $display("test control_reset done");

        // Wrap from the top value with no flag raised
        bus_wr(OFS_PR, 32'h0000_0000);
        bus_wr(OFS_TC, 32'h0000_FFFF);
        bus_wr(OFS_TCR, 32'h0000_0001);
        bus_wr(OFS_TCR, 32'h0000_0000);
        rd_chk("timer_count", OFS_TC, 32'h0000_0001);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0000);
        $display("test rollover done");

        // Channel 0 flags and toggles, channel 1 flags, drives low and halts
        bus_wr(OFS_TC, 32'h0000_0000);
        bus_wr(OFS_MR0, 32'h0000_0002);
        bus_wr(OFS_MR1, 32'h0000_0004);
        bus_wr(OFS_MCR, 32'h0000_0029);
        bus_wr(OFS_EMR, 32'h0000_0070);
        bus_wr(OFS_TCR, 32'h0000_0001);
        repeat (20) @(posedge ref_clk);
        rd_chk("timer_count", OFS_TC, 32'h0000_0004);
        rd_chk("timer_control", OFS_TCR, 32'h0000_0000);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0003);
        chk("match_outputs", 32'h0000_0001, {30'h0, match_outputs});
        chk("pin0_rises", 32'h0000_0001, {24'h0, pin0_rises});
        rd_chk("external_match_control", OFS_EMR, 32'h0000_0071);
        bus_wr(OFS_FLAGS, 32'h0000_0001);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0002);
        bus_wr(OFS_FLAGS, 32'h0000_0002);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0000);
        $display("test match_halt done");

        // Reset on match keeps the count at or below the match value
        bus_wr(OFS_MCR, 32'h0000_0002);
        bus_wr(OFS_TC, 32'h0000_0000);
        bus_wr(OFS_TCR, 32'h0000_0001);
        repeat (15) @(posedge ref_clk);
        bus_wr(OFS_TCR, 32'h0000_0000);
        rd_chk("timer_count", OFS_TC, 32'h0000_0002);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0000);
        bus_wr(OFS_MCR, 32'h0000_0000);
        $display("test match_reset done");

        // Rising-edge capture with flag; falling edge leaves the value
        bus_wr(OFS_TC, 32'h0000_1234);
        bus_wr(OFS_CCR, 32'h0000_0005);
        pin_flip();
        rd_chk("capture_value_0", OFS_CAP, 32'h0000_1234);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0010);
        bus_wr(OFS_TC, 32'h0000_5678);
        pin_flip();
        rd_chk("capture_value_0", OFS_CAP, 32'h0000_1234);
        bus_wr(OFS_FLAGS, 32'h0000_0010);
        rd_chk("interrupt_flags", OFS_FLAGS, 32'h0000_0000);
        bus_wr(OFS_CCR, 32'h0000_0000);
        $display("test capture done");

        // Counter modes: rising, falling, both edges over two pulses
        for (int m = 1; m <= 3; m++) begin
            bus_wr(OFS_COUNT_SOURCE_CONTROL, 32'(m));
            bus_wr(OFS_TC, 32'h0000_0000);
            bus_wr(OFS_TCR, 32'h0000_0001);
            repeat (4) pin_flip();
            bus_wr(OFS_TCR, 32'h0000_0000);
            rd_chk("counter mode count", OFS_TC, (m == 3) ? 32'h4 : 32'h2);
        end
        bus_wr(OFS_COUNT_SOURCE_CONTROL, 32'h0000_0000);
        $display("test counter_mode done");

        // Pin 0 follows count against match value 0 in PWM mode
        bus_wr(OFS_MR0, 32'h0000_0003);
        bus_wr(OFS_PWMC, 32'h0000_0001);
        bus_wr(OFS_TC, 32'h0000_0005);
        repeat (3) @(posedge ref_clk);
        chk("pwm pin high", 32'h0000_0001, {31'h0, match_outputs[0]});
        bus_wr(OFS_TC, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        chk("pwm pin low", 32'h0000_0000, {31'h0, match_outputs[0]});
        rd_chk("pwm_enable_control", OFS_PWMC, 32'h0000_0001);
        $display("test pwm done");

        finish_test();
    end
endmodule
